// ==== rtl/egress_qos_queue_scheduler.sv ====
// per-port egress classifier, four transmit queues and scheduler
`include "egress_qos_consts.svh"

//
// behaviour worth knowing
// - queue index 0 ranks highest; fill levels use the same index order.
// - disabled mode behaves exactly as first-come mode: oldest head first.
// - arrival ages compare modulo the stamp width, which outranges all stored.
// - a weight of zero parks its queue while weighted mode is selected.
// - a quota left partly used is restarted when the round comes back.
// - when only the current queue holds packets and its quota is spent,
//   a fresh round starts at once so the port never waits on bookkeeping.
// - a mode change keeps the round position, so the next weighted round
//   may start part way down the queues.
// - a packet refused for a full queue holds the fabric's stream until room.
// - the output buffer takes no pick while both entries are full, so the
//   egress data always comes from flops; this costs a cycle at that point.
// - configuration loads as a whole; a new mode applies from the next cycle.

module egress_qos_queue_scheduler #(
    parameter int DATA_W = `QOS_DATA_W,
    parameter int DEPTH = `QOS_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    // configuration load
    input wire logic cfg_wr_i,
    input wire egress_qos_pkg::qos_cfg_type cfg_i,
    output egress_qos_pkg::qos_cfg_type cfg_o,
    // packets from the forwarding fabric
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire egress_qos_pkg::ingress_pkt_type in_pkt_i,
    // packets toward the egress port
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [DATA_W-1:0] out_data_o,
    output logic [1:0] out_queue_o,
    // queue fill levels, lowest queue in the top field
    output logic [`QOS_NUM_QUEUES-1:0][$clog2(DEPTH):0] queue_fill_o
);
    import egress_qos_pkg::*;

    localparam int NQ = `QOS_NUM_QUEUES;
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    // stamps must outrange the total stored so ages never alias
    localparam int STAMP_W = $clog2(NQ * DEPTH) + 1;
    localparam int ENTRY_W = STAMP_W + DATA_W;
    localparam int WT_W = `QOS_WEIGHT_W;
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    // queue selected for a priority level through the map
    function automatic logic [1:0] queue_of(
        input logic [2:0] level,
        input logic [`QOS_NUM_LEVELS-1:0][1:0] lmap
    );
        queue_of = lmap[level];
    endfunction

    // pointer advance with wrap at the queue depth
    function automatic logic [PTR_W-1:0] ptr_next(
        input logic [PTR_W-1:0] p
    );
        ptr_next = (p == LAST_PTR) ? '0 : p + 1'b1;
    endfunction

    qos_cfg_type cfg_q;
    logic [ENTRY_W-1:0] mem_q [NQ][DEPTH];
    logic [PTR_W-1:0] wr_ptr_q [NQ];
    logic [PTR_W-1:0] rd_ptr_q [NQ];
    logic [CNT_W-1:0] cnt_q [NQ];
    logic [STAMP_W-1:0] stamp_q;
    logic [1:0] wrr_cur_q;
    logic [WT_W-1:0] wrr_used_q;
    logic [DATA_W-1:0] obuf_data_q [`QOS_OBUF_DEPTH];
    logic [1:0] obuf_queue_q [`QOS_OBUF_DEPTH];
    logic obuf_wr_q;
    logic obuf_rd_q;
    logic [1:0] obuf_cnt_q;

    logic [2:0] in_level;
    logic [1:0] in_queue;
    logic push;
    logic [NQ-1:0] nonempty;
    logic pick_ok;
    logic [1:0] pick_q;
    logic wrr_fresh; // spent queue opens a fresh round
    logic pop;
    logic obuf_pop;
    logic [STAMP_W-1:0] head_stamp [NQ];
    logic [STAMP_W-1:0] head_age [NQ];

    // configuration store; reset gives weighted 8:4:2:1 and paired map
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cfg_q.mode <= mode_wrr;
            cfg_q.weight[`QOS_Q_HIGHEST] <= `QOS_RST_W_HIGHEST;
            cfg_q.weight[`QOS_Q_SECOND_HIGH] <= `QOS_RST_W_SECOND_HIGH;
            cfg_q.weight[`QOS_Q_SECOND_LOW] <= `QOS_RST_W_SECOND_LOW;
            cfg_q.weight[`QOS_Q_LOWEST] <= `QOS_RST_W_LOWEST;
            cfg_q.level_map <= `QOS_RST_MAP;
            cfg_q.port_prio <= `QOS_RST_PORT_PRIO;
        end else if (cfg_wr_i) begin
            cfg_q <= cfg_i;
        end
    end

    assign cfg_o = cfg_q;

    // classify: tag priority if tagged, else the port's own priority
    always_comb begin
        in_level = in_pkt_i.prio_tagged ? in_pkt_i.tag_prio
                                        : cfg_q.port_prio;
        in_queue = queue_of(in_level, cfg_q.level_map);
    end

    // fabric stalls only while the chosen queue is full
    // a pop in the same cycle is not credited, keeping this path short
    assign in_ready_o = (cnt_q[in_queue] != FULL_CNT);
    assign push = in_valid_i && in_ready_o;

    // head stamps and ages relative to the arrival counter
    for (genvar g = 0; g < NQ; g++) begin : g_head
        assign nonempty[g] = (cnt_q[g] != '0);
        assign head_stamp[g] = mem_q[g][rd_ptr_q[g]][ENTRY_W-1:DATA_W];
        assign head_age[g] = stamp_q - head_stamp[g];
        assign queue_fill_o[g] = cnt_q[g];
    end

    // scheduler pick, one packet per cycle when the output buffer has room
    always_comb begin
        logic [1:0] cand;
        logic [STAMP_W-1:0] best_age;
        logic elig;
        cand = '0;
        best_age = '0;
        elig = 1'b0;
        pick_ok = 1'b0;
        pick_q = '0;
        wrr_fresh = 1'b0;
        unique case (cfg_q.mode)
            mode_disabled, mode_fcfs: begin
                // oldest head across queues keeps arrival order
                for (int i = 0; i < NQ; i++) begin
                    if (nonempty[i] && (!pick_ok || head_age[i] > best_age))
                    begin
                        pick_ok = 1'b1;
                        pick_q = 2'(i);
                        best_age = head_age[i];
                    end
                end
            end
            mode_strict: begin
                // first nonempty from the top wins
                // the loop ends on index 0, so the highest queue overrides
                for (int i = NQ - 1; i >= 0; i--) begin
                    if (nonempty[i]) begin
                        pick_ok = 1'b1;
                        pick_q = 2'(i);
                    end
                end
            end
            mode_wrr: begin
                // walk downward from the current queue, wrapping to the top
                for (int i = NQ - 1; i >= 0; i--) begin
                    cand = wrr_cur_q + 2'(i);
                    elig = nonempty[cand] && (cfg_q.weight[cand] != '0) &&
                           (i != 0 || wrr_used_q < cfg_q.weight[cand]);
                    if (elig) begin
                        pick_ok = 1'b1;
                        pick_q = cand;
                    end
                end
                // nothing else waits and the current quota is spent: the
                // round is over, so a fresh one starts here instead of
                // leaving the port idle
                if (!pick_ok && nonempty[wrr_cur_q] &&
                    (cfg_q.weight[wrr_cur_q] != '0)) begin
                    pick_ok = 1'b1;
                    pick_q = wrr_cur_q;
                    wrr_fresh = 1'b1;
                end
            end
        endcase
    end

    // a full buffer holds the pick back; the head stays in its queue
    assign pop = pick_ok && (obuf_cnt_q != 2'(`QOS_OBUF_DEPTH));

    // arrival stamp counter, advances with each stored packet
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            stamp_q <= '0;
        end else if (push) begin
            stamp_q <= stamp_q + 1'b1;
        end
    end

    // queue storage, no reset needed on the data array
    // the stamp rides with the data so arrival order survives the split
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_q[in_queue][wr_ptr_q[in_queue]] <= {stamp_q, in_pkt_i.data};
        end
    end

    // queue pointers and counts; push and pop may hit one queue together
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < NQ; i++) begin
                wr_ptr_q[i] <= '0;
                rd_ptr_q[i] <= '0;
                cnt_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NQ; i++) begin
                if (push && in_queue == 2'(i)) begin
                    wr_ptr_q[i] <= ptr_next(wr_ptr_q[i]);
                end
                if (pop && pick_q == 2'(i)) begin
                    rd_ptr_q[i] <= ptr_next(rd_ptr_q[i]);
                end
                if ((push && in_queue == 2'(i)) && !(pop && pick_q == 2'(i)))
                begin
                    cnt_q[i] <= cnt_q[i] + 1'b1;
                end else if (!(push && in_queue == 2'(i)) &&
                             (pop && pick_q == 2'(i))) begin
                    cnt_q[i] <= cnt_q[i] - 1'b1;
                end
            end
        end
    end

    // round state: stay on a queue until its quota is spent
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wrr_cur_q <= `QOS_Q_HIGHEST;
            wrr_used_q <= '0;
        end else if (pop && cfg_q.mode == mode_wrr) begin
            // a fresh round on the same queue restarts its quota count
            if (pick_q == wrr_cur_q && !wrr_fresh) begin
                wrr_used_q <= wrr_used_q + 1'b1;
            end else begin
                wrr_cur_q <= pick_q;
                wrr_used_q <= WT_W'(1);
            end
        end
    end

    // two-entry output buffer so a stalled port loses no packet
    assign obuf_pop = out_valid_o && out_ready_i;

    // buffer data is written on a pick and needs no reset
    always_ff @(posedge core_clk_i) begin
        if (pop) begin
            obuf_data_q[obuf_wr_q] <= mem_q[pick_q][rd_ptr_q[pick_q]]
                                           [DATA_W-1:0];
            obuf_queue_q[obuf_wr_q] <= pick_q;
        end
    end

    // buffer pointers and count; a pick and a take may meet in one cycle
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            obuf_wr_q <= 1'b0;
            obuf_rd_q <= 1'b0;
            obuf_cnt_q <= '0;
        end else begin
            if (pop) begin
                obuf_wr_q <= ~obuf_wr_q;
            end
            if (obuf_pop) begin
                obuf_rd_q <= ~obuf_rd_q;
            end
            if (pop && !obuf_pop) begin
                obuf_cnt_q <= obuf_cnt_q + 1'b1;
            end else if (!pop && obuf_pop) begin
                obuf_cnt_q <= obuf_cnt_q - 1'b1;
            end
        end
    end

    // outputs straight from buffer flops
    assign out_valid_o = (obuf_cnt_q != '0);
    assign out_data_o = obuf_data_q[obuf_rd_q];
    assign out_queue_o = obuf_queue_q[obuf_rd_q];

endmodule

// ==== rtl/egress_qos_consts.svh ====
// named constants for the egress quality-of-service queue scheduler
`ifndef EGRESS_QOS_CONSTS_SVH
`define EGRESS_QOS_CONSTS_SVH

// packet payload width carried through the queues
`define QOS_DATA_W 32
// number of transmit queues and priority levels
`define QOS_NUM_QUEUES 4
`define QOS_NUM_LEVELS 8
// queue indices, index 0 ranks highest
`define QOS_Q_HIGHEST 2'h0
`define QOS_Q_SECOND_HIGH 2'h1
`define QOS_Q_SECOND_LOW 2'h2
`define QOS_Q_LOWEST 2'h3
// default queue depth and weight field width
`define QOS_DEPTH 8
`define QOS_WEIGHT_W 4
// reset weights 8:4:2:1
`define QOS_RST_W_HIGHEST 4'h8
`define QOS_RST_W_SECOND_HIGH 4'h4
`define QOS_RST_W_SECOND_LOW 4'h2
`define QOS_RST_W_LOWEST 4'h1
// reset level map: 0-1 lowest, 2-3 second low, 4-5 second high, 6-7 highest
`define QOS_RST_MAP 16'h05AF
// reset priority for untagged packets of this port
`define QOS_RST_PORT_PRIO 3'h0
// output buffer entries
`define QOS_OBUF_DEPTH 2

`endif

// ==== rtl/egress_qos_pkg.sv ====
// types shared by the egress quality-of-service queue scheduler
`include "egress_qos_consts.svh"

package egress_qos_pkg;

    typedef enum logic [1:0] {
        mode_disabled,
        mode_fcfs,
        mode_strict,
        mode_wrr
    } qos_mode_type;

    // one packet as handed over by the forwarding fabric
    typedef struct packed {
        logic prio_tagged;
        logic [2:0] tag_prio;
        logic [`QOS_DATA_W-1:0] data;
    } ingress_pkt_type;

    // scheduler configuration, loaded by a strobe
    typedef struct packed {
        qos_mode_type mode;
        logic [`QOS_NUM_QUEUES-1:0][`QOS_WEIGHT_W-1:0] weight;
        logic [`QOS_NUM_LEVELS-1:0][1:0] level_map;
        logic [2:0] port_prio;
    } qos_cfg_type;

endpackage

// ==== testbench/egress_qos_assertions.sv ====
// port-level checks for the egress quality-of-service scheduler
module egress_qos_assertions import egress_qos_pkg::*; #(
    parameter int DATA_W = 32,
    parameter int DEPTH = 8
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic cfg_wr_i,
    input wire egress_qos_pkg::qos_cfg_type cfg_i,
    input wire egress_qos_pkg::qos_cfg_type cfg_o,
    input wire logic in_valid_i,
    input wire logic in_ready_o,
    input wire egress_qos_pkg::ingress_pkt_type in_pkt_i,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire logic [DATA_W-1:0] out_data_o,
    input wire logic [1:0] out_queue_o,
    input wire logic [3:0][$clog2(DEPTH):0] queue_fill_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // one domain, so clock and reset are stated once
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    a_out_hold_data: assert property (
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o)
        && $stable(out_queue_o)) else $error("stalled word changed");
    a_ready_with_room: assert property (
        !in_ready_o |-> queue_fill_o[0] == DEPTH || queue_fill_o[1] == DEPTH
        || queue_fill_o[2] == DEPTH || queue_fill_o[3] == DEPTH)
        else $error("refused with room left");
    a_cfg_load_take: assert property (
        cfg_wr_i |=> cfg_o == $past(cfg_i)) else $error("config not loaded");
    a_reset_mode_weights: assert property (
        $fell(srst_i) |-> cfg_o.mode == mode_wrr && cfg_o.weight == 16'h1248)
        else $error("reset mode or weights wrong");
    a_reset_level_map: assert property (
        $fell(srst_i) |-> cfg_o.level_map == 16'h05AF) else $error("reset map");
    a_fcfs_reach_out: assert property (
        cfg_o.mode == mode_fcfs && in_valid_i && in_ready_o && !out_valid_o
        |-> ##[1:3] out_valid_o) else $error("arrival never sent");
    a_strict_over_low: assert property (
        cfg_o.mode == mode_strict && $past(queue_fill_o[0]) != 0 |->
        queue_fill_o[1] >= $past(queue_fill_o[1]) && queue_fill_o[2] >=
        $past(queue_fill_o[2]) && queue_fill_o[3] >= $past(queue_fill_o[3]))
        else $error("lower queue served over top queue");
    a_wrr_no_idle: assert property (
        cfg_o.mode == mode_wrr && cfg_o.weight[0] != 0 && out_valid_o
        && queue_fill_o[0] != 0 |=> out_valid_o) else $error("link idled");

    // main scenarios reached
    c_refuse: cover property (in_valid_i && !in_ready_o);
    c_stall: cover property (out_valid_o && !out_ready_i);
    c_strict: cover property (cfg_o.mode == mode_strict && out_valid_o);
endmodule

// ==== testbench/egress_sink.sv ====
// egress port model: takes words, stalls on command, logs what it took
module egress_sink #(
    parameter int DATA_W = 32
) (
    input wire logic core_clk_i,
    input wire logic stall_i,
    input wire logic valid_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic [1:0] queue_i,
    output logic ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W+1:0] log_q[$];
    initial ready_o = 1'b0;
    // ready trails the stall request by one edge, like a busy port
    always @(posedge core_clk_i) begin
        if (valid_i && ready_o) begin
            log_q.push_back({queue_i, data_i});
        end
        ready_o <= !stall_i;
    end
endmodule

// ==== testbench/egress_qos_queue_scheduler_tb.sv ====
// self-checking bench for the egress quality-of-service scheduler
module egress_qos_queue_scheduler_tb import egress_qos_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic cfg_wr_i = 1'b0;
    qos_cfg_type cfg_i = '0;
    qos_cfg_type cfg_o;
    logic in_valid_i = 1'b0;
    logic in_ready_o;
    ingress_pkt_type in_pkt_i = '0;
    logic out_valid_o;
    logic out_ready_i;
    logic stall = 1'b1;
    logic [31:0] out_data_o;
    logic [1:0] out_queue_o;
    logic [3:0][3:0] queue_fill_o;
    int failures = 0;
    int checks = 0;
    always #2 core_clk_i = ~core_clk_i;
    egress_qos_queue_scheduler i_dut (.core_clk_i, .srst_i, .cfg_wr_i, .cfg_i,
        .cfg_o, .in_valid_i, .in_ready_o, .in_pkt_i, .out_valid_o, .out_ready_i,
        .out_data_o, .out_queue_o, .queue_fill_o);
    egress_sink i_sink (.core_clk_i, .stall_i(stall), .valid_i(out_valid_o),
        .data_i(out_data_o), .queue_i(out_queue_o), .ready_o(out_ready_i));

    task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // valid stays up between pushes so it is never driven twice in a step
    task automatic push(logic t, logic [2:0] p, logic [31:0] d);
        int n = 0;
        in_valid_i <= 1'b1;
        in_pkt_i <= '{t, p, d};
        @(negedge core_clk_i);
        while (in_ready_o !== 1'b1 && n++ < 99) @(negedge core_clk_i);
        if (n > 99) begin
            chk("ingress ready", 1, in_ready_o);
        end
        @(posedge core_clk_i);
    endtask
    // one byte per word expected: queue in the high nibble, id in the low
    task automatic drain(int n, logic [159:0] ex);
        logic [7:0] b;
        int k = 0;
        in_valid_i <= 1'b0;
        stall <= 1'b0;
        while (i_sink.log_q.size() < n && k++ < 200) @(posedge core_clk_i);
        for (int i = 0; i < n; i++) begin
            b = ex[159-8*i -: 8];
            chk("egress word", {b[5:4], 28'h0, b[3:0]}, i_sink.log_q[i]);
        end
        stall <= 1'b1;
        i_sink.log_q.delete();
        repeat (2) @(posedge core_clk_i);
    endtask
    // untagged packets take port priority 5, which maps to queue 1
    task automatic setcfg(qos_mode_type m, logic [15:0] w);
        in_valid_i <= 1'b0;
        cfg_i <= '{m, w, 16'h05AF, 3'h5};
        cfg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        cfg_wr_i <= 1'b0;
        @(posedge core_clk_i);
        chk("cfg", cfg_i, cfg_o);
    endtask

    task automatic t_reset();
        chk("reset cfg", qos_cfg_type'{mode_wrr, 16'h1248, 16'h05AF, 3'h0},
            cfg_o);
        chk("reset fill", 0, queue_fill_o);
        chk("reset valid", 0, out_valid_o);
    endtask
    // fillers park in the output buffer so the round starts fully stocked
    task automatic t_wrr();
        setcfg(mode_fcfs, 16'h1248);
        push(1'b1, 3'h0, 1);
        push(1'b1, 3'h1, 2);
        setcfg(mode_wrr, 16'h1248);
        repeat (8) push(1'b1, 3'h7, 3);
        in_pkt_i <= '{1'b1, 3'h6, 32'h3};
        @(negedge core_clk_i);
        chk("ready when full", 0, in_ready_o);
        @(posedge core_clk_i);
        repeat (5) push(1'b1, 3'h4, 4);
        repeat (3) push(1'b1, 3'h0, 5);
        drain(18, 160'h3132_0303_0303_0303_0303_1414_1414_3514_3535_0000);
    endtask
    // disabled and first-come both keep arrival order
    task automatic t_fcfs();
        for (int m = 0; m < 2; m++) begin
            setcfg(qos_mode_type'(m), 16'h1248);
            push(1'b1, 3'h0, 1);
            push(1'b1, 3'h7, 2);
            push(1'b1, 3'h2, 3);
            push(1'b1, 3'h5, 4);
            push(1'b0, 3'h7, 5);
            drain(5, {40'h3102_2314_15, 120'h0});
        end
    endtask
    task automatic t_strict();
        setcfg(mode_strict, 16'h1248);
        push(1'b1, 3'h1, 1);
        push(1'b1, 3'h0, 2);
        push(1'b0, 3'h7, 3);
        push(1'b1, 3'h0, 4);
        push(1'b1, 3'h6, 5);
        push(1'b1, 3'h3, 6);
        drain(6, {48'h3132_0513_2634, 112'h0});
    endtask
    // mid-run reset, then weights 1:2:1:1 that a fixed 8:4:2:1 cannot match
    task automatic t_weights();
        srst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        t_reset();
        setcfg(mode_wrr, 16'h1121);
        push(1'b1, 3'h0, 1);
        push(1'b1, 3'h0, 2);
        repeat (3) push(1'b1, 3'h7, 3);
        repeat (3) push(1'b1, 3'h4, 4);
        drain(8, {64'h3132_0314_1403_1403, 96'h0});
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        t_reset();
        t_wrr();
        t_fcfs();
        t_strict();
        t_weights();
        end_of_test();
    end
    // a hang anywhere above ends here
    initial begin
        repeat (5000) @(posedge core_clk_i);
        failures++;
        end_of_test();
    end
endmodule

bind egress_qos_queue_scheduler egress_qos_assertions #(.DATA_W(DATA_W),
    .DEPTH(DEPTH)) i_chk (.core_clk_i, .srst_i, .cfg_wr_i, .cfg_i, .cfg_o,
    .in_valid_i, .in_ready_o, .in_pkt_i, .out_valid_o, .out_ready_i,
    .out_data_o, .out_queue_o, .queue_fill_o);
